// ===== swb_map.svh
// Offsets, field positions, access limit and reset values for the subtract datapath.
// Assumes a 32-bit classic Wishbone slave, byte addressed, one word per register.
// Operation
// [RQ1] The result is memory operand minus working register minus inverted carry.
// [RQ2] Destination bit 0 writes the working register, 1 writes the memory operand back.
// [RQ3] Bank access bit 0 takes the operand from the shared low bank, ignoring bank select; above 0x5f the code uses the top page.
// [RQ4] Bank access bit 1 lets bank_select_reg supply the upper address bits.
// [RQ5] Access bit 0, extended set on and address up to 95 selects indexed literal offset.
// [RQ6] The instruction is one word and completes in one instruction cycle.
// [RQ7] Phases are decode, read operand, compute and write destination, in that order.
// [RQ8] The zero flag is 1 exactly when the eight-bit difference is zero.
// [RQ9] The negative flag is cleared when the result's top bit is zero.
// [RQ10] Execution updates negative, overflow, carry, digit carry and zero flags.
// [RQ11] Carry and digit carry are 1 when no borrow leaves bit 7 or bit 3.
`ifndef SWB_MAP_SVH
`define SWB_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define SWB_OFF_CTRL 8'h00
`define SWB_OFF_WREG 8'h04
`define SWB_OFF_STATUS 8'h08
`define SWB_OFF_BANK 8'h0c
`define SWB_OFF_XINST 8'h10
`define SWB_OFF_INDEX 8'h14
`define SWB_OFF_MADDR 8'h18
`define SWB_OFF_MDATA 8'h1c
`define SWB_OFF_LASTEA 8'h20
// ****************************************
// Control fields
// ****************************************
`define SWB_CTRL_F_MSB 7
`define SWB_CTRL_D_BIT 8
`define SWB_CTRL_A_BIT 9
`define SWB_CTRL_GO_BIT 16
`define SWB_CTRL_BUSY_BIT 24
`define SWB_GO_SEL 2
// ****************************************
// Addressing and reset values
// ****************************************
`define SWB_ACCESS_LIM 8'h5f
`define SWB_RST_BYTE 8'h00
`define SWB_RST_FLAGS 5'h00
`define SWB_RST_BIT 1'b0
`define SWB_DEF_D 1'b1
`define SWB_DEF_A 1'b1
`endif

// ===== swb_pkg.sv
// Types shared by the subtract-with-borrow datapath and its tests.
// Assumes the constants of swb_map.svh are included where needed.
package swb_pkg;
  // Execution phases, one instruction cycle of four
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1 = 3'b001,
    PH_Q2 = 3'b010,
    PH_Q3 = 3'b011,
    PH_Q4 = 3'b100
  } phase_t;
  // Status flags; c at bit 0 up to n at bit 4
  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } flags_t;
  // Wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage : swb_pkg

// ===== subtract_with_borrow_exec.sv
// Datapath for subtract_accum_with_borrow with its own data memory and registers.
// Assumes a classic Wishbone master on MCLK_I; no other clock, and no pin inputs besides RST_N_I.
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "swb_map.svh"
module subtract_with_borrow_exec
  import swb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Status
  output logic BUSY_O
);
  localparam int BANK_W = ADDR_W - 8;
  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < 9 || ADDR_W > 16) begin : g_chk
    $error("ADDR_W must lie between 9 and 16");
  end

  // Phase, instruction fields, datapath latches and software-visible registers
  typedef struct packed {
    phase_t ph;
    logic [7:0] f;
    logic d;
    logic a;
    logic [ADDR_W-1:0] ea;
    logic [7:0] op;
    logic [7:0] res;
    flags_t fn;
    logic [7:0] w;
    flags_t flg;
    logic [BANK_W-1:0] bank;
    logic xinst;
    logic [ADDR_W-1:0] idx;
    logic [ADDR_W-1:0] maddr;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] mem [DEPTH];
  wb_req_t rq;
  logic bus_req;
  logic wr;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [31:0] rd;
  logic [31:0] ctrl_cur;
  logic [31:0] ctrl_m;
  logic [8:0] sum8;
  logic [8:0] sum4;

  // ****************************************
  // Helpers
  // ****************************************
  // f + ~w + c equals f - w - borrow; bit 8 is the no-borrow carry
  function automatic logic [8:0] sub_brw(input logic [7:0] x, input logic [7:0] y,
                                         input logic cin);
    sub_brw = {1'b0, x} + {1'b0, ~y} + {8'h00, cin};
  endfunction : sub_brw

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~m) | (nw & m);
  endfunction : wmerge

  function automatic logic [31:0] zx(input logic [ADDR_W-1:0] v);
    zx = {{(32 - ADDR_W){1'b0}}, v};
  endfunction : zx

  // Operand address from the instruction's file field
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [7:0] f, input logic a,
      input logic xi, input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] idx);
    if (a) begin
      eff_addr = {bank, f}; // RQ4
    end else if (xi && f <= `SWB_ACCESS_LIM) begin
      eff_addr = ADDR_W'(idx + {{BANK_W{1'b0}}, f}); // RQ5
    end else if (f <= `SWB_ACCESS_LIM) begin
      eff_addr = {{BANK_W{1'b0}}, f}; // RQ3
    end else begin
      // Access addresses above 0x5f land in the top page, bank bits all ones
      eff_addr = {{BANK_W{1'b1}}, f}; // RQ3
    end
  endfunction : eff_addr

  assign rq = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                sel: WB_SEL_I, dat: WB_DAT_I};
  assign bus_req = rq.cyc & rq.stb;
  // Write lands on the edge where the master sees ack
  assign wr = bus_req & rq.we & s_q.ack;
  assign ctrl_cur = {7'h00, s_q.ph != PH_IDLE, 14'h0000, s_q.a, s_q.d, s_q.f};
  assign ctrl_m = wmerge(ctrl_cur, rq.dat, rq.sel);
  assign sum8 = sub_brw(s_q.op, s_q.w, s_q.flg.c);
  assign sum4 = sub_brw({4'h0, s_q.op[3:0]}, {4'hf, s_q.w[3:0]}, s_q.flg.c);

  // ****************************************
  // Read mux
  // ****************************************
  // Unmapped offsets read zero
  always_comb begin
    rd = 32'h0000_0000;
    if (rq.adr == `SWB_OFF_CTRL) begin
      rd = ctrl_cur;
    end else if (rq.adr == `SWB_OFF_WREG) begin
      rd = {24'h000000, s_q.w};
    end else if (rq.adr == `SWB_OFF_STATUS) begin
      rd = {27'h0000000, s_q.flg};
    end else if (rq.adr == `SWB_OFF_BANK) begin
      rd = zx({8'h00, s_q.bank});
    end else if (rq.adr == `SWB_OFF_XINST) begin
      rd = {31'h00000000, s_q.xinst};
    end else if (rq.adr == `SWB_OFF_INDEX) begin
      rd = zx(s_q.idx);
    end else if (rq.adr == `SWB_OFF_MADDR) begin
      rd = zx(s_q.maddr);
    end else if (rq.adr == `SWB_OFF_MDATA) begin
      rd = {24'h000000, mem[s_q.maddr]};
    end else if (rq.adr == `SWB_OFF_LASTEA) begin
      rd = zx(s_q.ea);
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_wa = s_q.maddr;
    mem_wd = rq.dat[7:0];
    // Ack only while idle so software never races the datapath
    s_d.ack = bus_req & ~s_q.ack & (s_q.ph == PH_IDLE);
    if (s_d.ack) begin
      s_d.dat = rd;
    end
    if (wr) begin
      if (rq.adr == `SWB_OFF_CTRL) begin
        s_d.f = ctrl_m[`SWB_CTRL_F_MSB:0];
        s_d.d = ctrl_m[`SWB_CTRL_D_BIT];
        s_d.a = ctrl_m[`SWB_CTRL_A_BIT];
        if (rq.sel[`SWB_GO_SEL] && rq.dat[`SWB_CTRL_GO_BIT]) begin
          s_d.ph = PH_Q1;
        end
      end else if (rq.adr == `SWB_OFF_WREG) begin
        s_d.w = 8'(wmerge({24'h000000, s_q.w}, rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_STATUS) begin
        s_d.flg = 5'(wmerge({27'h0000000, s_q.flg}, rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_BANK) begin
        s_d.bank = BANK_W'(wmerge(zx({8'h00, s_q.bank}), rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_XINST) begin
        s_d.xinst = 1'(wmerge({31'h00000000, s_q.xinst}, rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_INDEX) begin
        s_d.idx = ADDR_W'(wmerge(zx(s_q.idx), rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_MADDR) begin
        s_d.maddr = ADDR_W'(wmerge(zx(s_q.maddr), rq.dat, rq.sel));
      end else if (rq.adr == `SWB_OFF_MDATA) begin
        mem_we = rq.sel[0];
      end
    end
    case (s_q.ph) // RQ6 RQ7
      PH_Q1: begin
        s_d.ea = eff_addr(s_q.f, s_q.a, s_q.xinst, s_q.bank, s_q.idx);
        s_d.ph = PH_Q2;
      end
      PH_Q2: begin
        s_d.op = mem[s_q.ea];
        s_d.ph = PH_Q3;
      end
      PH_Q3: begin
        s_d.res = sum8[7:0]; // RQ1
        s_d.fn.c = sum8[8]; // RQ11
        s_d.fn.digit_carry_flag = sum4[4]; // RQ11
        s_d.fn.z = (sum8[7:0] == 8'h00); // RQ8
        s_d.fn.n = sum8[7]; // RQ9
        s_d.fn.overflow_flag = (s_q.op[7] != s_q.w[7]) && (sum8[7] != s_q.op[7]); // RQ10
        s_d.ph = PH_Q4;
      end
      PH_Q4: begin
        if (s_q.d) begin
          mem_we = 1'b1; // RQ2
          mem_wa = s_q.ea;
          mem_wd = s_q.res;
        end else begin
          s_d.w = s_q.res; // RQ2
        end
        s_d.flg = s_q.fn; // RQ10
        s_d.ph = PH_IDLE;
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.ph <= PH_IDLE;
      s_q.d <= `SWB_DEF_D;
      s_q.a <= `SWB_DEF_A;
      s_q.w <= `SWB_RST_BYTE;
      s_q.flg <= `SWB_RST_FLAGS;
      s_q.xinst <= `SWB_RST_BIT;
    end else begin
      s_q <= s_d;
    end
  end

  // Memory is not reset; software loads it first
  always_ff @(posedge MCLK_I) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.dat;
  assign BUSY_O = s_q.ph != PH_IDLE;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_DIFF: assert property (s_q.ph == PH_Q4 |-> // RQ1
    s_q.res == 8'(s_q.op - s_q.w - {7'h00, ~s_q.flg.c})) else $error("difference wrong");
  AST_DEST_W: assert property (s_q.ph == PH_Q4 && !s_q.d |=> // RQ2
    s_q.w == $past(s_q.res)) else $error("working register not written");
  AST_DEST_F: assert property (s_q.ph == PH_Q4 && s_q.d |=> // RQ2
    mem[s_q.ea] == $past(s_q.res) && s_q.w == $past(s_q.w)) else $error("file not written");
  AST_ACCESS: assert property (s_q.ph == PH_Q2 && !s_q.a && // RQ3
    !(s_q.xinst && s_q.f <= `SWB_ACCESS_LIM) |->
    s_q.ea[ADDR_W-1:8] == {BANK_W{s_q.f > `SWB_ACCESS_LIM}} && s_q.ea[7:0] == s_q.f)
    else $error("access bank address wrong");
  AST_BANK: assert property (s_q.ph == PH_Q2 && s_q.a |-> // RQ4
    s_q.ea == {s_q.bank, s_q.f}) else $error("banked address wrong");
  AST_INDEXED: assert property (s_q.ph == PH_Q2 && !s_q.a && s_q.xinst && // RQ5
    s_q.f <= `SWB_ACCESS_LIM |-> s_q.ea == ADDR_W'(s_q.idx + s_q.f))
    else $error("indexed address wrong");
  AST_PHASES: assert property (s_q.ph == PH_Q1 |=> // RQ6
    s_q.ph == PH_Q2 ##1 s_q.ph == PH_Q3 ##1 s_q.ph == PH_Q4 ##1 s_q.ph == PH_IDLE)
    else $error("phase order broken");
  AST_OPREAD: assert property (s_q.ph == PH_Q2 |=> // RQ7
    s_q.op == $past(mem[s_q.ea])) else $error("operand not read in second phase");
  AST_ZERO: assert property (s_q.ph == PH_Q4 |=> // RQ8
    s_q.flg.z == ($past(s_q.res) == 8'h00)) else $error("zero flag wrong");
  AST_NEG: assert property (s_q.ph == PH_Q4 && !s_q.res[7] |=> // RQ9
    !s_q.flg.n) else $error("negative flag wrong");
  AST_OV: assert property (s_q.ph == PH_Q3 |=> ##1 s_q.flg.overflow_flag == // RQ10
    ($past(s_q.op[7], 2) != $past(s_q.w[7], 2) && $past(s_q.res[7]) != $past(s_q.op[7], 2)))
    else $error("overflow flag wrong");
  AST_CARRY: assert property (s_q.ph == PH_Q3 |=> ##1 s_q.flg.c == // RQ11
    ($past(s_q.op, 2) >= 9'($past(s_q.w, 2)) + 9'(!$past(s_q.flg.c, 2))))
    else $error("carry flag wrong");
  AST_DCARRY: assert property (s_q.ph == PH_Q3 |=> ##1 s_q.flg.digit_carry_flag == // RQ11
    ($past(s_q.op[3:0], 2) >= 5'($past(s_q.w[3:0], 2)) + 5'(!$past(s_q.flg.c, 2))))
    else $error("digit carry flag wrong");
  AST_NEG_UPD: assert property (s_q.ph == PH_Q4 |=> // RQ10
    s_q.flg.n == $past(s_q.res[7])) else $error("negative flag not updated");
  AST_KEEP_F: assert property (s_q.ph == PH_Q4 && !s_q.d |=> // RQ2
    mem[s_q.ea] == $past(mem[s_q.ea])) else $error("file changed for working destination");

  // ****************************************
  // Bus and timing checks
  // ****************************************
  // One-cycle ack lets the master release on the edge where it sees it
  AST_ACK_PULSE: assert property (WB_ACK_O |=>
    !WB_ACK_O) else $error("ack longer than one cycle");
  // Software must never see an ack in the middle of an instruction
  AST_NO_ACK_BUSY: assert property (BUSY_O |=>
    !WB_ACK_O) else $error("ack given while busy");
  AST_GO_START: assert property (wr && rq.adr == `SWB_OFF_CTRL && // RQ7
    rq.sel[`SWB_GO_SEL] && rq.dat[`SWB_CTRL_GO_BIT] |=> s_q.ph == PH_Q1)
    else $error("start request did not begin decode");
  AST_BUSY_LEN: assert property ($rose(BUSY_O) |-> // RQ6
    BUSY_O [*4] ##1 !BUSY_O) else $error("instruction not four phases long");
  AST_EA_HOLD: assert property (BUSY_O && s_q.ph != PH_Q1 |=> // RQ7
    $stable(s_q.ea)) else $error("operand address moved during execution");
  AST_OP_HOLD: assert property (s_q.ph == PH_Q3 |=> // RQ7
    $stable(s_q.op)) else $error("operand moved after the read phase");

  COV_TO_W: cover property (s_q.ph == PH_Q4 && !s_q.d);
  COV_TO_F: cover property (s_q.ph == PH_Q4 && s_q.d);
  COV_INDEXED: cover property (s_q.ph == PH_Q1 && !s_q.a && s_q.xinst);
  COV_ZERO: cover property (s_q.ph == PH_Q4 && s_q.res == 8'h00);
  COV_BORROW: cover property (s_q.ph == PH_Q4 && !s_q.fn.c);
endmodule : subtract_with_borrow_exec

// ===== wb_master_model.sv
// Classic Wishbone master standing in for the decoder side of the datapath.
// Assumes a slave that answers each request with a one-cycle ack.
`timescale 1ns/100ps
module wb_master_model (
  // Clock and answer
  input wire logic mclk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Holds every request line until the edge that samples ack high, giving up after 40 clocks
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    int n;
    @(posedge mclk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge mclk_i);
      ok = (ack_i === 1'b1);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released address and data lines show junk, not the last value; we and sel keep it
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : wb_master_model

// ===== subtract_with_borrow_exec_tb.sv
// Self-checking bench: random instructions against an integer model.
// Assumes the register map and one-cycle ack described for the datapath.
`timescale 1ns/100ps
`include "swb_map.svh"
module subtract_with_borrow_exec_tb
  import swb_pkg::*;
;
  logic mclk, rst_n, cyc, stb, we, ack, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, seed;
  int mismatches, comparisons, runlen, lastrun;
  subtract_with_borrow_exec subtract_with_borrow_exec_inst (.MCLK_I(mclk), .RST_N_I(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BUSY_O(busy));
  wb_master_model wb_master_model_inst (.mclk_i(mclk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Length of the last busy run, in clocks
  always @(posedge mclk) begin
    if (busy === 1'b1) runlen <= runlen + 1;
    else if (runlen != 0) begin
      lastrun <= runlen;
      runlen <= 0;
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task chk_flags(input flags_t e, input flags_t g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected flags expected %b seen %b", e, g);
    end
  endtask : chk_flags
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    bit ok;
    wb_master_model_inst.xfer(w, a, d, q, ok);
    if (!ok) begin
      mismatches++;
      wrap_up();
    end
  endtask : bus
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [11:0] ea, idx;
    logic [7:0] f, w, m, r;
    logic [3:0] bank;
    logic c, b, d, a, x;
    flags_t e;
    mismatches = 0;
    comparisons = 0;
    runlen = 0;
    lastrun = 0;
    seed = 32'heb817cbe;
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, `SWB_OFF_CTRL, 32'h0, q);
    chk_val("ctrl", 32'h300, q);
    bus(1'b0, `SWB_OFF_STATUS, 32'h0, q);
    chk_val("status", 32'h0, q);
    bus(1'b1, 8'h24, 32'h5a, q);
    bus(1'b0, 8'h24, 32'h0, q);
    chk_val("unmapped", 32'h0, q);
    for (int i = 0; i < 60; i++) begin
      w = 8'(xs());
      m = 8'(xs());
      q = xs();
      {bank, x, a, d, c} = q[7:0];
      idx = 12'(xs());
      f = (i < 4) ? 8'({8'h5f, 8'h60, 8'h00, 8'hff} >> (8 * i)) : 8'(xs());
      b = !c;
      if (i == 4) m = w + b;
      // Addressing model: bank, shared low or top page, indexed
      ea = a ? {bank, f} : (f <= `SWB_ACCESS_LIM ? (x ? idx + f : {4'h0, f}) : {4'hf, f});
      r = m - w - b;
      e.c = {1'b0, m} >= {1'b0, w} + b;
      e.digit_carry_flag = {1'b0, m[3:0]} >= {1'b0, w[3:0]} + b;
      e.z = (r == 8'h00);
      e.n = r[7];
      e.overflow_flag = (m[7] ^ w[7]) & (m[7] ^ r[7]);
      bus(1'b1, `SWB_OFF_MADDR, 32'(ea), q);
      bus(1'b1, `SWB_OFF_MDATA, 32'(m), q);
      bus(1'b1, `SWB_OFF_WREG, 32'(w), q);
      bus(1'b1, `SWB_OFF_STATUS, 32'(c), q);
      bus(1'b1, `SWB_OFF_BANK, 32'(bank), q);
      bus(1'b1, `SWB_OFF_XINST, 32'(x), q);
      bus(1'b1, `SWB_OFF_INDEX, 32'(idx), q);
      bus(1'b1, `SWB_OFF_CTRL, {15'h0, 1'b1, 6'h0, a, d, f}, q);
      bus(1'b0, `SWB_OFF_LASTEA, 32'h0, q);
      chk_val("address", 32'(ea), q);
      chk_val("cycles", 4, lastrun);
      bus(1'b0, `SWB_OFF_WREG, 32'h0, q);
      chk_val("wreg", 32'(d ? w : r), q);
      bus(1'b0, `SWB_OFF_MDATA, 32'h0, q);
      chk_val("memory", 32'(d ? r : m), q);
      bus(1'b0, `SWB_OFF_CTRL, 32'h0, q);
      chk_val("ctrl", {22'h000000, a, d, f}, q);
      bus(1'b0, `SWB_OFF_STATUS, 32'h0, q);
      chk_flags(e, q[4:0]);
    end
    bus(1'b1, `SWB_OFF_LASTEA, 32'hfff, q);
    bus(1'b0, `SWB_OFF_LASTEA, 32'h0, q);
    chk_val("lastea", 32'(ea), q);
    wrap_up();
  end
endmodule : subtract_with_borrow_exec_tb
